// File: rtl/mem_out_pkg.sv
// Purpose: Shared constants, register map and helpers for the memory port output control
// Assumes: 100 MHz single clock, AXI4-Lite register access with 32-bit data
// Notes: Configuration bit positions are shared by both ports

package mem_out_pkg;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;

  // ----------------------------------------------------------------
  // Build-time reset values of the port outputs
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESET_VALUE_A = 16'hffff;
  localparam logic [DATA_W-1:0] RESET_VALUE_B = 16'h0000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] OFS_CFG_A = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] OFS_CFG_B = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] OFS_DOUT = 4'h8;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 4'hc;

  // ----------------------------------------------------------------
  // Port configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_W = 6;
  localparam int CFG_USE_RST = 0;
  localparam int CFG_USE_REGCE = 1;
  localparam int CFG_PRIM_REG = 2;
  localparam int CFG_CORE_REG = 3;
  localparam int CFG_LATCH_RST = 4;
  localparam int CFG_RST_FIRST = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h05;

  // Status fields, per port: effective latch reset and read latency
  localparam int LAT_W = 2;
  localparam int STAT_B_SHIFT = 8;
  localparam int STAT_LAT_LSB = 0;
  localparam int STAT_LRST = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [DATA_W-1:0] data_type;
  typedef logic [CFG_W-1:0] cfg_type;

  // Latch reset is only honoured with a primitive register and no core register
  function automatic logic latch_rst_allowed(input cfg_type cfg);
    latch_rst_allowed = cfg[CFG_LATCH_RST] & cfg[CFG_PRIM_REG] & ~cfg[CFG_CORE_REG];
  endfunction : latch_rst_allowed

  // Read latency: one cycle for the latch plus one per optional register stage
  function automatic logic [LAT_W-1:0] read_latency(input cfg_type cfg);
    read_latency = 2'h1 + {1'b0, cfg[CFG_PRIM_REG]} + {1'b0, cfg[CFG_CORE_REG]};
  endfunction : read_latency

  // Next value of an output register with selectable reset/enable priority
  function automatic data_type stage_next(input logic rst_first, input logic ce, input logic rst_hit,
                                          input data_type d, input data_type q, input data_type rv);
    if (rst_first && rst_hit) begin
      stage_next = rv;
    end else if (ce) begin
      stage_next = rst_hit ? rv : d;
    end else begin
      stage_next = q;
    end
  endfunction : stage_next

endpackage : mem_out_pkg

// File: rtl/port_out_stage.sv
// Purpose: Output path of one memory port: latch, primitive register, core register
// Assumes: Inputs synchronous to clock; read data arrives combinationally from the array
// Notes: dout is a flop loaded with the next value of whichever stage is last

`timescale 1ns/1ps

module port_out_stage #(
  parameter mem_out_pkg::data_type RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire mem_out_pkg::cfg_type cfg,
  input wire logic en,
  input wire logic regce,
  input wire logic port_rst,
  input wire mem_out_pkg::data_type rd_data,
  output mem_out_pkg::data_type dout
);
  import mem_out_pkg::*;

  data_type latch_q, latch_d;
  data_type prim_q, prim_d;
  data_type core_q, core_d;
  data_type dout_q;
  logic use_prim, use_core, rst_first, rst_in;
  logic rst_ram, rst_prim, rst_core;
  logic last_ce, prim_ce;

  // ----------------------------------------------------------------
  // Reset and enable steering
  // ----------------------------------------------------------------
  assign use_prim = cfg[CFG_PRIM_REG];
  assign use_core = cfg[CFG_CORE_REG];
  // Priority only matters for output registers; the latch always obeys en
  assign rst_first = cfg[CFG_RST_FIRST] & (use_prim | use_core);
  assign rst_in = cfg[CFG_USE_RST] & port_rst;
  // Separate latch and register resets; latch reset only when it is last or opted in
  assign rst_ram = rst_in & ((~use_prim & ~use_core) | latch_rst_allowed(cfg));
  assign rst_prim = rst_in & use_prim & ~use_core;
  assign rst_core = rst_in & use_core;
  // Last register follows regce when selected, otherwise en
  assign last_ce = cfg[CFG_USE_REGCE] ? regce : en;
  assign prim_ce = use_core ? en : last_ce;

  // ----------------------------------------------------------------
  // Stage next values
  // ----------------------------------------------------------------
  always_comb begin
    latch_d = en ? (rst_ram ? RESET_VALUE : rd_data) : latch_q;
    prim_d = stage_next(rst_first, prim_ce, rst_prim, latch_q, prim_q, RESET_VALUE);
    core_d = stage_next(rst_first, last_ce, rst_core, use_prim ? prim_q : latch_q, core_q,
                        RESET_VALUE);
  end

  // ----------------------------------------------------------------
  // Stages; each optional stage adds one cycle of latency
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
      prim_q <= '0;
      core_q <= '0;
    end else begin
      latch_q <= latch_d;
      prim_q <= prim_d;
      core_q <= core_d;
    end
  end

  // Output flop mirrors the last stage so the port output is registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout_q <= '0;
    end else if (use_core) begin
      dout_q <= core_d;
    end else if (use_prim) begin
      dout_q <= prim_d;
    end else begin
      dout_q <= latch_d;
    end
  end

  assign dout = dout_q;

endmodule : port_out_stage

// File: rtl/mem_out_ctrl.sv
// Purpose: Dual-port memory with configurable output reset and flow control per port
// Assumes: One 100 MHz clock; port controls synchronous to it; AXI4-Lite for configuration
// Notes: Both ports write the shared array; on a same-address collision port B's write wins

`timescale 1ns/1ps

module mem_out_ctrl (
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [mem_out_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [mem_out_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port A
  input wire logic en_a,
  input wire logic we_a,
  input wire logic [mem_out_pkg::ADDR_W-1:0] addr_a,
  input wire mem_out_pkg::data_type din_a,
  input wire logic regce_a,
  input wire logic port_rst_a,
  output mem_out_pkg::data_type dout_a,
  // Memory port B
  input wire logic en_b,
  input wire logic we_b,
  input wire logic [mem_out_pkg::ADDR_W-1:0] addr_b,
  input wire mem_out_pkg::data_type din_b,
  input wire logic regce_b,
  input wire logic port_rst_b,
  output mem_out_pkg::data_type dout_b
);
  import mem_out_pkg::*;

  // ----------------------------------------------------------------
  // Storage and configuration state
  // ----------------------------------------------------------------
  data_type mem_q [DEPTH];
  cfg_type cfg_a_q, cfg_b_q;

  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [AXI_ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic have_aw_q, have_w_q;
  logic do_write, do_read;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic [31:0] status_w;

  // ----------------------------------------------------------------
  // Shared memory array
  // ----------------------------------------------------------------
  // Read-first: the latch picks up the old word while a write lands
  always_ff @(posedge clock) begin
    if (en_a && we_a) begin
      mem_q[addr_a] <= din_a;
    end
    if (en_b && we_b) begin
      mem_q[addr_b] <= din_b;
    end
  end

  // ----------------------------------------------------------------
  // Port output paths
  // ----------------------------------------------------------------
  port_out_stage #(
    .RESET_VALUE(RESET_VALUE_A)
  ) u_stage_a (
    .clock(clock),
    .rst(rst),
    .cfg(cfg_a_q),
    .en(en_a),
    .regce(regce_a),
    .port_rst(port_rst_a),
    .rd_data(mem_q[addr_a]),
    .dout(dout_a)
  );

  // Same logic, its own configuration and reset value
  port_out_stage #(
    .RESET_VALUE(RESET_VALUE_B)
  ) u_stage_b (
    .clock(clock),
    .rst(rst),
    .cfg(cfg_b_q),
    .en(en_b),
    .regce(regce_b),
    .port_rst(port_rst_b),
    .rd_data(mem_q[addr_b]),
    .dout(dout_b)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are captured independently, in either order
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      have_aw_q <= 1'b0;
      waddr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      have_aw_q <= 1'b1;
      waddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      have_aw_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      have_w_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      have_w_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      have_w_q <= 1'b0;
    end
  end

  // Ready drops once an item is held so a second write waits for the response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      awready_q <= ~have_aw_q & ~(s_axi_awvalid & awready_q) & ~bvalid_q;
      wready_q <= ~have_w_q & ~(s_axi_wvalid & wready_q) & ~bvalid_q;
    end
  end

  assign do_write = have_aw_q & have_w_q & ~bvalid_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (waddr_q == OFS_CFG_A || waddr_q == OFS_CFG_B) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries fields; a new setting applies from the next cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_a_q <= CFG_RESET;
    end else if (do_write && waddr_q == OFS_CFG_A && wstrb_q[0]) begin
      cfg_a_q <= wdata_q[CFG_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_b_q <= CFG_RESET;
    end else if (do_write && waddr_q == OFS_CFG_B && wstrb_q[0]) begin
      cfg_b_q <= wdata_q[CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  always_comb begin
    status_w = '0;
    status_w[STAT_LAT_LSB +: LAT_W] = read_latency(cfg_a_q);
    status_w[STAT_LRST] = latch_rst_allowed(cfg_a_q);
    status_w[STAT_B_SHIFT + STAT_LAT_LSB +: LAT_W] = read_latency(cfg_b_q);
    status_w[STAT_B_SHIFT + STAT_LRST] = latch_rst_allowed(cfg_b_q);
  end

  always_comb begin
    rdata_d = '0;
    rresp_d = RESP_OKAY;
    case (s_axi_araddr)
      OFS_CFG_A: rdata_d[CFG_W-1:0] = cfg_a_q;
      OFS_CFG_B: rdata_d[CFG_W-1:0] = cfg_b_q;
      OFS_DOUT: rdata_d = {dout_b, dout_a};
      OFS_STATUS: rdata_d = status_w;
      default: rresp_d = RESP_SLVERR;
    endcase
  end

  assign do_read = s_axi_arvalid & arready_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= ~rvalid_q & ~do_read;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : mem_out_ctrl

// File: tb/port_fabric_model.sv
// Purpose: Fabric logic that drives one memory port's controls
// Assumes: Controls are synchronous to clock
// Notes: Every change lands just after a rising edge, as fabric flops would

`timescale 1ns/1ps

module port_fabric_model (
  input wire logic clock,
  output logic en,
  output logic we,
  output logic [mem_out_pkg::ADDR_W-1:0] addr,
  output mem_out_pkg::data_type din,
  output logic regce,
  output logic port_rst
);
  import mem_out_pkg::*;

  initial begin
    en = 1'b0;
    we = 1'b0;
    addr = '0;
    din = '0;
    regce = 1'b0;
    port_rst = 1'b0;
  end

  // One clock cycle of control values, held until the next call
  task automatic step(input logic e, input logic w, input logic [ADDR_W-1:0] a, input data_type d,
                      input logic g, input logic r);
    @(posedge clock);
    en <= e;
    we <= w;
    addr <= a;
    din <= d;
    regce <= g;
    port_rst <= r;
  endtask : step
endmodule : port_fabric_model

// File: tb/mem_out_ctrl_checker.sv
// Purpose: Concurrent checks on output reset of both ports and flow control of port A
// Assumes: Port configuration changes only through completed register writes
// Notes: Configuration is shadowed from the write channels, one cycle behind the design

`timescale 1ns/1ps

module mem_out_ctrl_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [mem_out_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic en_a,
  input wire logic regce_a,
  input wire logic port_rst_a,
  input wire mem_out_pkg::data_type dout_a,
  input wire logic en_b,
  input wire logic port_rst_b,
  input wire mem_out_pkg::data_type dout_b
);
  import mem_out_pkg::*;

  cfg_type ca_q;
  cfg_type cb_q;
  logic [AXI_ADDR_W-1:0] wa_q;
  cfg_type wd_q;

  // ----------------------------------------------------------------
  // Configuration shadow
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wa_q <= '0;
      wd_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ca_q <= CFG_RESET;
      cb_q <= CFG_RESET;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (wa_q == OFS_CFG_A) ca_q <= wd_q;
      if (wa_q == OFS_CFG_B) cb_q <= wd_q;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_rst_en_a;
    ca_q[CFG_USE_RST] && !ca_q[CFG_USE_REGCE] && port_rst_a && en_a;
  endsequence
  sequence s_latch_two_a;
    (ca_q[CFG_LATCH_RST] && ca_q[CFG_PRIM_REG] && !ca_q[CFG_CORE_REG] && ca_q[CFG_USE_RST] &&
     !ca_q[CFG_USE_REGCE] && port_rst_a && en_a) ##1 en_a;
  endsequence

  property p_rst_en_a;
    s_rst_en_a |=> dout_a == RESET_VALUE_A;
  endproperty
  property p_latch_two_a;
    s_latch_two_a |=> dout_a == RESET_VALUE_A;
  endproperty
  property p_ef_hold_a;
    !ca_q[CFG_RST_FIRST] && !ca_q[CFG_USE_REGCE] && !en_a |=> $stable(dout_a);
  endproperty
  property p_latch_prio_a;
    !ca_q[CFG_PRIM_REG] && !ca_q[CFG_CORE_REG] && !ca_q[CFG_USE_REGCE] && !en_a |=> $stable(dout_a);
  endproperty
  property p_sr_a;
    ca_q[CFG_RST_FIRST] && ca_q[CFG_USE_RST] && (ca_q[CFG_PRIM_REG] || ca_q[CFG_CORE_REG]) && port_rst_a
      |=> dout_a == RESET_VALUE_A;
  endproperty
  property p_regce_hold_a;
    ca_q[CFG_USE_REGCE] && (ca_q[CFG_PRIM_REG] || ca_q[CFG_CORE_REG]) && !regce_a &&
      !(port_rst_a && ca_q[CFG_RST_FIRST] && ca_q[CFG_USE_RST]) |=> $stable(dout_a);
  endproperty
  property p_regce_rst_a;
    ca_q[CFG_USE_RST] && ca_q[CFG_USE_REGCE] && (ca_q[CFG_PRIM_REG] || ca_q[CFG_CORE_REG]) &&
      port_rst_a && regce_a |=> dout_a == RESET_VALUE_A;
  endproperty
  property p_rst_en_b;
    cb_q[CFG_USE_RST] && !cb_q[CFG_USE_REGCE] && port_rst_b && en_b |=> dout_b == RESET_VALUE_B;
  endproperty
  property p_sr_b;
    cb_q[CFG_RST_FIRST] && cb_q[CFG_USE_RST] && (cb_q[CFG_PRIM_REG] || cb_q[CFG_CORE_REG]) && port_rst_b
      |=> dout_b == RESET_VALUE_B;
  endproperty

  a_rst_en_a: assert property (p_rst_en_a)
    else $error("port a reset with enable did not load the reset value");
  a_latch_two_a: assert property (p_latch_two_a)
    else $error("port a latch reset did not hold a second cycle");
  a_ef_hold_a: assert property (p_ef_hold_a)
    else $error("port a output moved with enable low");
  a_latch_prio_a: assert property (p_latch_prio_a)
    else $error("port a latch changed with enable low");
  a_sr_a: assert property (p_sr_a)
    else $error("port a reset-first reset ignored");
  a_regce_hold_a: assert property (p_regce_hold_a)
    else $error("port a last register moved with register enable low");
  a_regce_rst_a: assert property (p_regce_rst_a)
    else $error("port a reset with register enable missed");
  a_rst_en_b: assert property (p_rst_en_b)
    else $error("port b reset with enable did not load the reset value");
  a_sr_b: assert property (p_sr_b)
    else $error("port b reset-first reset ignored");
endmodule : mem_out_ctrl_checker

bind mem_out_ctrl mem_out_ctrl_checker u_chk (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .en_a, .regce_a, .port_rst_a,
  .dout_a, .en_b, .port_rst_b, .dout_b);

// File: tb/mem_out_ctrl_tb_top.sv
// Purpose: Directed tests of port output reset, priority and read latency
// Assumes: Port A holds 1234 at 5 and 5a5a at 3, port B holds 00c3 at 7
// Notes: Idle state keeps enables high so configuration changes never race a held output

`timescale 1ns/1ps

module mem_out_ctrl_tb_top;
  import mem_out_pkg::*;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [AXI_ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic en_a, we_a, regce_a, port_rst_a, en_b, we_b, regce_b, port_rst_b;
  logic [ADDR_W-1:0] addr_a, addr_b;
  data_type din_a, din_b, dout_a, dout_b;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] rd;
  cfg_type lat_cfg[3] = '{6'h01, 6'h05, 6'h0d};
  int lat_exp[3] = '{1, 2, 3};

  initial begin
    forever #5 clock = ~clock;
  end

  mem_out_ctrl u_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .en_a, .we_a, .addr_a, .din_a,
    .regce_a, .port_rst_a, .dout_a, .en_b, .we_b, .addr_b, .din_b, .regce_b, .port_rst_b, .dout_b);
  port_fabric_model u_fab_a (.clock, .en(en_a), .we(we_a), .addr(addr_a), .din(din_a), .regce(regce_a),
    .port_rst(port_rst_a));
  port_fabric_model u_fab_b (.clock, .en(en_b), .we(we_b), .addr(addr_b), .din(din_b), .regce(regce_b),
    .port_rst(port_rst_b));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Waits only on the slave's answer; a stuck bus is caught by the watchdog
  task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask : axi_wr

  task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
  endtask : axi_rd

  task automatic fab(input bit pb, input logic e, input logic g, input logic r);
    if (pb) u_fab_b.step(e, 1'b0, 4'h7, 16'h0000, g, r);
    else u_fab_a.step(e, 1'b0, 4'h5, 16'h0000, g, r);
  endtask : fab

  // One-cycle port reset under given enables; counts cycles showing the reset value
  task automatic rcase(input bit pb, input cfg_type c, input logic e, input logic g, input int exp);
    logic [31:0] n;
    n = '0;
    axi_wr(pb ? OFS_CFG_B : OFS_CFG_A, {26'h0, c}, RESP_OKAY);
    repeat (4) fab(pb, 1'b1, 1'b1, 1'b0);
    fab(pb, e, g, 1'b1);
    repeat (5) begin
      fab(pb, e, g, 1'b0);
      #1;
      if ((pb ? dout_b : dout_a) === (pb ? RESET_VALUE_B : RESET_VALUE_A)) n++;
    end
    fab(pb, 1'b1, 1'b1, 1'b0);
    chk(n, 32'(exp), "cycles at reset value");
  endtask : rcase

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    axi_rd(OFS_DOUT, rd, RESP_OKAY);
    chk(rd, 32'h0, "outputs after reset");
    // Read-only and unmapped words answer with an error and change nothing
    axi_wr(OFS_DOUT, 32'h0000_003f, RESP_SLVERR);
    axi_rd(4'h1, rd, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read data");
    axi_rd(OFS_CFG_B, rd, RESP_OKAY);
    chk(rd, {26'h0, CFG_RESET}, "port b config reset value");
    axi_rd(OFS_CFG_A, rd, RESP_OKAY);
    chk(rd, {26'h0, CFG_RESET}, "config reset value");
    u_fab_a.step(1'b1, 1'b1, 4'h5, 16'h1234, 1'b1, 1'b0);
    u_fab_a.step(1'b1, 1'b1, 4'h3, 16'h5a5a, 1'b1, 1'b0);
    u_fab_b.step(1'b1, 1'b1, 4'h7, 16'h00c3, 1'b1, 1'b0);
    foreach (lat_cfg[k]) begin
      axi_wr(OFS_CFG_A, {26'h0, lat_cfg[k]}, RESP_OKAY);
      repeat (4) u_fab_a.step(1'b1, 1'b0, 4'h5, 16'h0000, 1'b1, 1'b0);
      u_fab_a.step(1'b1, 1'b0, 4'h3, 16'h0000, 1'b1, 1'b0);
      for (int i = 1; i <= lat_exp[k] + 1; i++) begin
        u_fab_a.step(1'b1, 1'b0, 4'h5, 16'h0000, 1'b1, 1'b0);
        #1;
        chk({16'h0, dout_a}, (i == lat_exp[k]) ? 32'h5a5a : 32'h1234, "read latency");
      end
    end
    axi_rd(OFS_DOUT, rd, RESP_OKAY);
    chk(rd, 32'h00c3_1234, "output word of both ports");
    rcase(1'b0, 6'h05, 1'b1, 1'b1, 1);
    rcase(1'b0, 6'h15, 1'b1, 1'b1, 2);
    axi_rd(OFS_STATUS, rd, RESP_OKAY);
    chk(rd, 32'h0000_0212, "status latency and latch reset");
    rcase(1'b0, 6'h01, 1'b1, 1'b1, 1);
    rcase(1'b0, 6'h05, 1'b0, 1'b1, 0);
    rcase(1'b0, 6'h25, 1'b0, 1'b1, 5);
    rcase(1'b0, 6'h21, 1'b0, 1'b1, 0);
    rcase(1'b0, 6'h17, 1'b1, 1'b0, 0);
    rcase(1'b0, 6'h17, 1'b0, 1'b1, 1);
    rcase(1'b0, 6'h07, 1'b1, 1'b0, 0);
    rcase(1'b0, 6'h27, 1'b1, 1'b0, 5);
    rcase(1'b0, 6'h04, 1'b1, 1'b1, 0);
    rcase(1'b0, 6'h1d, 1'b1, 1'b1, 1);
    rcase(1'b0, 6'h19, 1'b1, 1'b1, 1);
    rcase(1'b1, 6'h15, 1'b1, 1'b1, 2);
    rcase(1'b1, 6'h25, 1'b0, 1'b1, 5);
    conclude();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule : mem_out_ctrl_tb_top
